//--- shared/tao_pkg.sv
package tao_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_HYST     = 8'h08;
  localparam logic [7:0] OFS_OFFSET   = 8'h0C;
  localparam logic [7:0] OFS_LOC_HIGH = 8'h10;
  localparam logic [7:0] OFS_LOC_LOW  = 8'h14;
  localparam logic [7:0] OFS_REM_HIGH = 8'h18;
  localparam logic [7:0] OFS_REM_LOW  = 8'h1C;
  localparam logic [7:0] OFS_LOC_FAIL = 8'h20;
  localparam logic [7:0] OFS_REM_FAIL = 8'h24;
  localparam logic [7:0] OFS_LOC_VAL  = 8'h28;
  localparam logic [7:0] OFS_REM_VAL  = 8'h2C;
  localparam logic [7:0] OFS_PINS     = 8'h30;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int unsigned CTRL_W        = 2;
  localparam int unsigned CTRL_MASK     = 0;
  localparam int unsigned CTRL_PINMODE  = 1;
  localparam int unsigned STATUS_W      = 5;
  localparam int unsigned ST_LOC_HIGH   = 0;
  localparam int unsigned ST_LOC_LOW    = 1;
  localparam int unsigned ST_OPEN       = 2;
  localparam int unsigned ST_REM_HIGH   = 3;
  localparam int unsigned ST_REM_LOW    = 4;
  localparam int unsigned PIN_FAIL_DRV  = 0;
  localparam int unsigned PIN_ALARM_DRV = 1;
  localparam int unsigned PIN_FAIL_LVL  = 2;
  localparam int unsigned PIN_ALARM_LVL = 3;
  localparam int unsigned PINS_W        = 4;
  localparam int unsigned SYNC_N        = 3;
  localparam int unsigned IN_OPEN       = 0;
  localparam int unsigned IN_FAIL       = 1;
  localparam int unsigned IN_ALARM      = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [CTRL_W-1:0]   RST_CTRL   = 2'h0;
  localparam logic [STATUS_W-1:0] RST_STATUS = 5'h00;
  localparam logic [7:0]          RST_HYST   = 8'h0A;
  localparam logic [7:0]          RST_OFFSET = 8'h00;
  localparam logic [7:0]          RST_HIGH   = 8'h7F;
  localparam logic [7:0]          RST_LOW    = 8'h00;
  localparam logic [7:0]          RST_FAIL   = 8'h55;
  localparam logic [7:0]          RST_VAL    = 8'h00;

  // ****************************************
  // Arithmetic limits
  // ****************************************
  localparam logic signed [9:0] TEMP_MAX = 10'h07F;
  localparam logic signed [9:0] TEMP_MIN = 10'h380;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic [7:0] fail;
  } tao_limits_t;

  typedef struct packed {
    logic overHigh;
    logic atLow;
    logic failTrip;
    logic secTrip;
  } tao_cmp_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tao_wb_req_t;

  typedef enum logic [2:0] {
    ALERT_IDLE  = 3'b001,
    ALERT_ON    = 3'b010,
    ALERT_ACKED = 3'b100
  } tao_alert_t;

endpackage

//--- src/tao_chan_cmp.sv
`timescale 1ns/10ps
module tao_chan_cmp (
  input  wire logic [7:0]          value,
  input  wire tao_pkg::tao_limits_t limits,
  input  wire logic [7:0]          hyst,
  input  wire logic                failTripQ,
  input  wire logic                secTripQ,
  output tao_pkg::tao_cmp_t        result
);
  import tao_pkg::*;

  // ****************************************
  // Signed operands
  // ****************************************
  logic signed [9:0] val;
  logic signed [9:0] hi;
  logic signed [9:0] lo;
  logic signed [9:0] fs;
  logic signed [9:0] fsRel;
  logic signed [9:0] hiRel;

  assign val   = {{2{value[7]}}, value};
  assign hi    = {{2{limits.high[7]}}, limits.high};
  assign lo    = {{2{limits.low[7]}}, limits.low};
  assign fs    = {{2{limits.fail[7]}}, limits.fail};
  assign fsRel = fs - $signed({2'h0, hyst});
  assign hiRel = hi - $signed({2'h0, hyst});

  // ****************************************
  // Comparisons
  // ****************************************
  always_comb begin
    result.overHigh = (val > hi);
    result.atLow    = (val <= lo);
    if (val > fs) begin
      result.failTrip = 1'b1;
    end else if (val <= fsRel) begin
      result.failTrip = 1'b0;
    end else begin
      result.failTrip = failTripQ;
    end
    if (val > hi) begin
      result.secTrip = 1'b1;
    end else if (val <= hiRel) begin
      result.secTrip = 1'b0;
    end else begin
      result.secTrip = secTripQ;
    end
  end

endmodule

//--- src/tao_alarm_top.sv
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
module tao_alarm_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire tao_pkg::tao_wb_req_t wbReq,
  output logic                      wbAck,
  output logic [31:0]               wbDatO,
  input  wire logic [7:0]           locResult,
  input  wire logic                 locResultValid,
  input  wire logic [7:0]           remResult,
  input  wire logic                 remResultValid,
  input  wire logic                 convStart,
  input  wire logic                 openSense,
  input  wire logic                 araRead,
  output logic                      araHit,
  output logic [6:0]                araAddr,
  input  wire logic                 failsafeTripNIn,
  output logic                      failsafeTripNOut,
  output logic                      failsafeTripNOe,
  input  wire logic                 alarmPinNIn,
  output logic                      alarmPinNOut,
  output logic                      alarmPinNOe
);
  import tao_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic                ack_q, ack_d;
  logic [31:0]         dat_q, dat_d;
  logic [CTRL_W-1:0]   ctrl_q, ctrl_d;
  logic [STATUS_W-1:0] status_q, status_d;
  logic [7:0]          hyst_q, hyst_d;
  logic [7:0]          offset_q, offset_d;
  tao_limits_t         locLim_q, locLim_d;
  tao_limits_t         remLim_q, remLim_d;
  logic [7:0]          locVal_q, locVal_d;
  logic [7:0]          remVal_q, remVal_d;
  logic                eval_q, eval_d;
  logic                openCond_q, openCond_d;
  logic                locFail_q, locFail_d;
  logic                remFail_q, remFail_d;
  logic                locSec_q, locSec_d;
  logic                remSec_q, remSec_d;
  tao_alert_t          alert_q, alert_d;
  logic                failOut_q, failOut_d;
  logic                failOe_q, failOe_d;
  logic                alarmOut_q, alarmOut_d;
  logic                alarmOe_q, alarmOe_d;
  logic                araHit_q, araHit_d;
  logic [6:0]          araAddr_q;
  logic [SYNC_N-1:0]   sync_q [SYNC_N];
  logic [SYNC_N-1:0]   sync_d [SYNC_N];
  logic [SYNC_N-1:0]   filt_q, filt_d;
  logic                req;
  logic                wrEn;
  logic                limWrite;
  logic                setEvent;
  logic                cond;
  logic                alertActive;
  tao_cmp_t            locCmp;
  tao_cmp_t            remCmp;
  logic [2:0]          inPins;

  localparam logic [SYNC_N-1:0] FILT_RST = ~(SYNC_N'(1) << IN_OPEN);

  // ****************************************
  // Offset add with saturation
  // ****************************************
  function automatic logic [7:0] satAdd(input logic [7:0] raw, input logic [7:0] ofs);
    logic signed [9:0] sum;
    sum = $signed({{2{raw[7]}}, raw}) + $signed({{2{ofs[7]}}, ofs});
    if (sum > TEMP_MAX) begin
      satAdd = TEMP_MAX[7:0];
    end else if (sum < TEMP_MIN) begin
      satAdd = TEMP_MIN[7:0];
    end else begin
      satAdd = sum[7:0];
    end
  endfunction

  // ****************************************
  // Channel comparators
  // ****************************************
  tao_chan_cmp uLocCmp (
    .value     (locVal_q),
    .limits    (locLim_q),
    .hyst      (hyst_q),
    .failTripQ (locFail_q),
    .secTripQ  (locSec_q),
    .result    (locCmp)
  );

  tao_chan_cmp uRemCmp (
    .value     (remVal_q),
    .limits    (remLim_q),
    .hyst      (hyst_q),
    .failTripQ (remFail_q),
    .secTripQ  (remSec_q),
    .result    (remCmp)
  );

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  assign inPins = {alarmPinNIn, failsafeTripNIn, openSense};

  always_comb begin
    for (int i = 0; i < SYNC_N; i++) begin
      sync_d[i] = {sync_q[i][SYNC_N-2:0], inPins[i]};
      filt_d[i] = (sync_q[i][1] == sync_q[i][2]) ? sync_q[i][2] : filt_q[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < SYNC_N; i++) begin
        sync_q[i] <= {SYNC_N{FILT_RST[i]}};
      end
      filt_q <= FILT_RST;
    end else begin
      sync_q <= sync_d;
      filt_q <= filt_d;
    end
  end

  // ****************************************
  // Wishbone slave and registers
  // ****************************************
  assign req      = wbReq.cyc & wbReq.stb;
  assign wrEn     = req & wbReq.we & ack_q & wbReq.sel[0];
  assign limWrite = wrEn & ((wbReq.adr == OFS_LOC_HIGH) | (wbReq.adr == OFS_LOC_LOW) |
                            (wbReq.adr == OFS_REM_HIGH) | (wbReq.adr == OFS_REM_LOW) |
                            (wbReq.adr == OFS_LOC_FAIL) | (wbReq.adr == OFS_REM_FAIL) |
                            (wbReq.adr == OFS_HYST));

  always_comb begin
    ack_d    = req & ~ack_q;
    dat_d    = dat_q;
    ctrl_d   = ctrl_q;
    hyst_d   = hyst_q;
    offset_d = offset_q;
    locLim_d = locLim_q;
    remLim_d = remLim_q;
    locVal_d = locVal_q;
    remVal_d = remVal_q;
    if (wrEn) begin
      case (wbReq.adr)
        OFS_CTRL:     ctrl_d        = wbReq.dat[CTRL_W-1:0];
        OFS_HYST:     hyst_d        = wbReq.dat[7:0];
        OFS_OFFSET:   offset_d      = wbReq.dat[7:0];
        OFS_LOC_HIGH: locLim_d.high = wbReq.dat[7:0];
        OFS_LOC_LOW:  locLim_d.low  = wbReq.dat[7:0];
        OFS_REM_HIGH: remLim_d.high = wbReq.dat[7:0];
        OFS_REM_LOW:  remLim_d.low  = wbReq.dat[7:0];
        OFS_LOC_FAIL: locLim_d.fail = wbReq.dat[7:0];
        OFS_REM_FAIL: remLim_d.fail = wbReq.dat[7:0];
        default:      ;
      endcase
    end
    if (locResultValid) begin
      locVal_d = satAdd(locResult, offset_q);
    end
    if (remResultValid) begin
      remVal_d = satAdd(remResult, offset_q);
    end
    if (ack_d) begin
      case (wbReq.adr)
        OFS_CTRL:     dat_d = {30'h0, ctrl_q};
        OFS_STATUS:   dat_d = {27'h0, status_q};
        OFS_HYST:     dat_d = {24'h0, hyst_q};
        OFS_OFFSET:   dat_d = {24'h0, offset_q};
        OFS_LOC_HIGH: dat_d = {24'h0, locLim_q.high};
        OFS_LOC_LOW:  dat_d = {24'h0, locLim_q.low};
        OFS_REM_HIGH: dat_d = {24'h0, remLim_q.high};
        OFS_REM_LOW:  dat_d = {24'h0, remLim_q.low};
        OFS_LOC_FAIL: dat_d = {24'h0, locLim_q.fail};
        OFS_REM_FAIL: dat_d = {24'h0, remLim_q.fail};
        OFS_LOC_VAL:  dat_d = {24'h0, locVal_q};
        OFS_REM_VAL:  dat_d = {24'h0, remVal_q};
        OFS_PINS:     dat_d = {28'h0, filt_q[IN_ALARM], filt_q[IN_FAIL], alarmOe_q, failOe_q};
        default:      dat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ack_q    <= 1'b0;
      dat_q    <= 32'h0000_0000;
      ctrl_q   <= RST_CTRL;
      hyst_q   <= RST_HYST;
      offset_q <= RST_OFFSET;
      locLim_q <= '{high: RST_HIGH, low: RST_LOW, fail: RST_FAIL};
      remLim_q <= '{high: RST_HIGH, low: RST_LOW, fail: RST_FAIL};
      locVal_q <= RST_VAL;
      remVal_q <= RST_VAL;
    end else begin
      ack_q    <= ack_d;
      dat_q    <= dat_d;
      ctrl_q   <= ctrl_d;
      hyst_q   <= hyst_d;
      offset_q <= offset_d;
      locLim_q <= locLim_d;
      remLim_q <= remLim_d;
      locVal_q <= locVal_d;
      remVal_q <= remVal_d;
    end
  end

  // ****************************************
  // Evaluation, status and trip state
  // ****************************************
  assign cond     = locCmp.overHigh | locCmp.atLow | remCmp.overHigh | remCmp.atLow | openCond_q;
  assign setEvent = (eval_q & (locCmp.overHigh | locCmp.atLow | remCmp.overHigh | remCmp.atLow)) |
                    (convStart & filt_q[IN_OPEN]);

  always_comb begin
    eval_d     = locResultValid | remResultValid | limWrite;
    openCond_d = convStart ? filt_q[IN_OPEN] : openCond_q;
    status_d   = status_q;
    if (wrEn && (wbReq.adr == OFS_STATUS)) begin
      status_d = status_q & ~wbReq.dat[STATUS_W-1:0];
    end
    if (eval_q) begin
      status_d[ST_LOC_HIGH] = status_d[ST_LOC_HIGH] | locCmp.overHigh;
      status_d[ST_LOC_LOW]  = status_d[ST_LOC_LOW] | locCmp.atLow;
      status_d[ST_REM_HIGH] = status_d[ST_REM_HIGH] | remCmp.overHigh;
      status_d[ST_REM_LOW]  = status_d[ST_REM_LOW] | remCmp.atLow;
    end
    if (convStart && filt_q[IN_OPEN]) begin
      status_d[ST_OPEN] = 1'b1;
    end
    locFail_d = eval_q ? locCmp.failTrip : locFail_q;
    remFail_d = eval_q ? remCmp.failTrip : remFail_q;
    locSec_d  = eval_q ? locCmp.secTrip : locSec_q;
    remSec_d  = eval_q ? remCmp.secTrip : remSec_q;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      eval_q     <= 1'b0;
      openCond_q <= 1'b0;
      status_q   <= RST_STATUS;
      locFail_q  <= 1'b0;
      remFail_q  <= 1'b0;
      locSec_q   <= 1'b0;
      remSec_q   <= 1'b0;
    end else begin
      eval_q     <= eval_d;
      openCond_q <= openCond_d;
      status_q   <= status_d;
      locFail_q  <= locFail_d;
      remFail_q  <= remFail_d;
      locSec_q   <= locSec_d;
      remSec_q   <= remSec_d;
    end
  end

  // ****************************************
  // Alert state machine
  // ****************************************
  assign alertActive = (alert_q != ALERT_IDLE) & ~ctrl_q[CTRL_MASK] & ~ctrl_q[CTRL_PINMODE];

  always_comb begin
    alert_d = alert_q;
    case (alert_q)
      ALERT_IDLE: begin
        if (setEvent) begin
          alert_d = ALERT_ON;
        end
      end
      ALERT_ON: begin
        if (araRead && alertActive) begin
          alert_d = ALERT_ACKED;
        end
      end
      ALERT_ACKED: begin
        if (setEvent) begin
          alert_d = ALERT_ON;
        end else if ((status_d == RST_STATUS) && !cond) begin
          alert_d = ALERT_IDLE;
        end
      end
      default: alert_d = ALERT_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      alert_q <= ALERT_IDLE;
    end else begin
      alert_q <= alert_d;
    end
  end

  // ****************************************
  // Output drivers
  // ****************************************
  always_comb begin
    failOe_d  = locFail_q | remFail_q;
    failOut_d = ~failOe_d;
    if (ctrl_q[CTRL_PINMODE]) begin
      alarmOe_d = locSec_q | remSec_q;
    end else begin
      alarmOe_d = alertActive;
    end
    alarmOut_d = ~alarmOe_d;
    araHit_d   = alertActive;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      failOut_q  <= 1'b1;
      failOe_q   <= 1'b0;
      alarmOut_q <= 1'b1;
      alarmOe_q  <= 1'b0;
      araHit_q   <= 1'b0;
      araAddr_q  <= 7'h00;
    end else begin
      failOut_q  <= failOut_d;
      failOe_q   <= failOe_d;
      alarmOut_q <= alarmOut_d;
      alarmOe_q  <= alarmOe_d;
      araHit_q   <= araHit_d;
      araAddr_q  <= DEV_ADDR;
    end
  end

  assign wbAck            = ack_q;
  assign wbDatO           = dat_q;
  assign araHit           = araHit_q;
  assign araAddr          = araAddr_q;
  assign failsafeTripNOut = failOut_q;
  assign failsafeTripNOe  = failOe_q;
  assign alarmPinNOut     = alarmOut_q;
  assign alarmPinNOe      = alarmOe_q;

endmodule

//--- bench/tao_alarm_assertions.sv
`timescale 1ns/10ps
module tao_alarm_assertions #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input wire logic                 mclk,
  input wire logic                 nrst,
  input wire tao_pkg::tao_wb_req_t wbReq,
  input wire logic                 wbAck,
  input wire logic [31:0]          wbDatO,
  input wire logic                 locResultValid,
  input wire logic                 remResultValid,
  input wire logic                 convStart,
  input wire logic                 araRead,
  input wire logic                 araHit,
  input wire logic [6:0]           araAddr,
  input wire logic                 failsafeTripNOut,
  input wire logic                 failsafeTripNOe,
  input wire logic                 alarmPinNOut,
  input wire logic                 alarmPinNOe
);
  import tao_pkg::*;
  // ****************************************
  // Causes of an evaluation
  // ****************************************
  logic evtF;
  logic evtA;
  assign evtF = locResultValid || remResultValid || (wbAck && wbReq.we);
  assign evtA = evtF || convStart || araRead;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_req;
    wbReq.cyc && wbReq.stb && !wbAck;
  endsequence
  sequence s_ack;
    wbAck ##1 !wbAck;
  endsequence
  // ****************************************
  // Checks
  // ****************************************
  a_ack_timing: assert property (s_req |=> s_ack)
    else $error("ack not a single pulse one cycle after request");
  a_ack_cause: assert property (wbAck |-> $past(wbReq.cyc && wbReq.stb))
    else $error("ack without request");
  a_unmapped_zero: assert property (wbAck && !wbReq.we && wbReq.adr > OFS_PINS |-> wbDatO == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (wbAck |-> wbDatO[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_fs_level: assert property (failsafeTripNOut == !failsafeTripNOe)
    else $error("fail-safe output not active low");
  a_alarm_level: assert property (alarmPinNOut == !alarmPinNOe)
    else $error("alarm output not active low");
  a_reset_idle: assert property ($rose(nrst) |-> !failsafeTripNOe && !alarmPinNOe)
    else $error("outputs asserted after reset");
  a_ara_addr: assert property (araHit |-> araAddr == DEV_ADDR)
    else $error("alert response address wrong");
  a_ara_pin: assert property (araHit |-> alarmPinNOe)
    else $error("alert response without asserted alert");
  a_fs_cause: assert property ($changed(failsafeTripNOe) |->
    $past(evtF, 2) || $past(evtF, 3) || $past(evtF, 4) || $past(evtF, 5) || $past(evtF, 6))
    else $error("fail-safe changed without evaluation");
  a_alarm_cause: assert property ($changed(alarmPinNOe) |->
    $past(evtA, 2) || $past(evtA, 3) || $past(evtA, 4) || $past(evtA, 5) || $past(evtA, 6))
    else $error("alarm changed without evaluation");
endmodule

bind tao_alarm_top tao_alarm_assertions #(.DEV_ADDR(DEV_ADDR)) uChk (
  .mclk(mclk), .nrst(nrst), .wbReq(wbReq), .wbAck(wbAck), .wbDatO(wbDatO),
  .locResultValid(locResultValid), .remResultValid(remResultValid), .convStart(convStart),
  .araRead(araRead), .araHit(araHit), .araAddr(araAddr), .failsafeTripNOut(failsafeTripNOut),
  .failsafeTripNOe(failsafeTripNOe), .alarmPinNOut(alarmPinNOut), .alarmPinNOe(alarmPinNOe)
);

//--- bench/tao_smbus_host.sv
`timescale 1ns/10ps
module tao_smbus_host (
  input  wire logic araReq,
  input  wire logic failOe,
  input  wire logic alarmOe,
  output logic      failLine,
  output logic      alarmLine,
  output logic      araRead
);
  // Pull-ups on both open-drain lines
  assign failLine  = !failOe;
  assign alarmLine = !alarmOe;
  // Host reads the alert response only while the shared line is low
  assign araRead   = araReq && !alarmLine;
endmodule

//--- bench/tao_alarm_top_bench.sv
`timescale 1ns/10ps
module tao_alarm_top_bench;
  import tao_pkg::*;
  localparam logic [6:0] ADDR = 7'h15; // Arbitrary device address
  logic        mclk = 1'b0, nrst = 1'b0, locResultValid = 1'b0, remResultValid = 1'b0;
  logic        convStart = 1'b0, openSense = 1'b0, araReq = 1'b0;
  logic [7:0]  locResult = 8'h00, remResult = 8'h00;
  tao_wb_req_t req = '0;
  logic        wbAck, araRead, araHit, failLine, alarmLine;
  logic        failsafeTripNOut, failsafeTripNOe, alarmPinNOut, alarmPinNOe;
  logic [31:0] wbDatO;
  logic [6:0]  araAddr;
  int          bad_count = 0, n_checks = 0;
  always #25 mclk = ~mclk;
  tao_alarm_top #(.DEV_ADDR(ADDR)) dut (
    .mclk(mclk), .nrst(nrst), .wbReq(req), .wbAck(wbAck), .wbDatO(wbDatO),
    .locResult(locResult), .locResultValid(locResultValid), .remResult(remResult),
    .remResultValid(remResultValid), .convStart(convStart), .openSense(openSense),
    .araRead(araRead), .araHit(araHit), .araAddr(araAddr), .failsafeTripNIn(failLine),
    .failsafeTripNOut(failsafeTripNOut), .failsafeTripNOe(failsafeTripNOe), .alarmPinNIn(alarmLine),
    .alarmPinNOut(alarmPinNOut), .alarmPinNOe(alarmPinNOe));
  tao_smbus_host host (.araReq(araReq), .failOe(failsafeTripNOe), .alarmOe(alarmPinNOe),
    .failLine(failLine), .alarmLine(alarmLine), .araRead(araRead));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: {24'h000000, d}};
    do begin
      @(posedge mclk);
      n++;
      if (n > 20) begin
        bad_count++;
        give_verdict();
      end
    end while (wbAck !== 1'b1);
    q = wbDatO;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, q);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    logic [31:0] q;
    wb(1'b0, adr, 8'h00, q);
    chk(q, {24'h000000, exp});
  endtask
  task automatic settle();
    repeat (6) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic push(input logic loc, input logic [7:0] v);
    @(posedge mclk);
    if (loc) begin
      locResult <= v;
      locResultValid <= 1'b1;
    end else begin
      remResult <= v;
      remResultValid <= 1'b1;
    end
    @(posedge mclk);
    locResultValid <= 1'b0;
    remResultValid <= 1'b0;
    settle();
  endtask
  task automatic strobe(input logic isAra);
    @(posedge mclk);
    if (isAra) begin
      araReq <= 1'b1;
    end else begin
      convStart <= 1'b1;
    end
    @(posedge mclk);
    araReq <= 1'b0;
    convStart <= 1'b0;
    settle();
  endtask
  task automatic pins(input logic fs, input logic al);
    chk(32'(failsafeTripNOe), 32'(fs));
    chk(32'(alarmPinNOe), 32'(al));
    chk(32'(failsafeTripNOut), 32'(!fs));
    chk(32'(alarmPinNOut), 32'(!al));
  endtask
  task automatic clean();
    push(1'b1, 8'h20);
    push(1'b0, 8'h20);
    wr(OFS_STATUS, 8'h1F);
    strobe(1'b1);
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    pins(1'b0, 1'b0);
    rd(OFS_HYST, 8'h0A);
    rd(OFS_LOC_FAIL, 8'h55);
    rd(OFS_REM_FAIL, 8'h55);
    rd(8'h40, 8'h00);
    wr(OFS_LOC_LOW, 8'h80);
    wr(OFS_REM_LOW, 8'h80);
    wr(OFS_LOC_HIGH, 8'h30); // Local fail-safe limit stays above the local high limit
    clean();
    push(1'b1, 8'h31);
    rd(OFS_STATUS, 8'h01);
    pins(1'b0, 1'b1);
    chk(32'(araHit), 32'h1);
    chk(32'(araAddr), 32'(ADDR));
    wr(OFS_CTRL, 8'h01);
    settle();
    pins(1'b0, 1'b0);
    wr(OFS_CTRL, 8'h00);
    push(1'b1, 8'h20);
    wr(OFS_STATUS, 8'h1F);
    settle();
    pins(1'b0, 1'b1);
    rd(OFS_STATUS, 8'h00);
    strobe(1'b1);
    pins(1'b0, 1'b0);
    wr(OFS_LOC_HIGH, 8'h10);
    settle();
    pins(1'b0, 1'b1);
    rd(OFS_STATUS, 8'h01);
    wr(OFS_LOC_HIGH, 8'h30);
    clean();
    pins(1'b0, 1'b0);
    push(1'b1, 8'h56);
    pins(1'b1, 1'b1);
    rd(OFS_PINS, 8'h03);
    push(1'b1, 8'h4C);
    pins(1'b1, 1'b1);
    push(1'b1, 8'h4B);
    pins(1'b0, 1'b1);
    wr(OFS_HYST, 8'h05);
    rd(OFS_HYST, 8'h05);
    push(1'b0, 8'h56);
    chk(32'(failsafeTripNOe), 32'h1);
    push(1'b0, 8'h51);
    chk(32'(failsafeTripNOe), 32'h1);
    push(1'b0, 8'h50);
    chk(32'(failsafeTripNOe), 32'h0);
    rd(OFS_PINS, 8'h06);
    clean();
    wr(OFS_OFFSET, 8'hFE);
    wr(OFS_LOC_LOW, 8'h10);
    push(1'b1, 8'h12);
    push(1'b0, 8'h81);
    rd(OFS_LOC_VAL, 8'h10);
    rd(OFS_REM_VAL, 8'h80);
    rd(OFS_STATUS, 8'h12);
    wr(OFS_OFFSET, 8'h00);
    wr(OFS_LOC_LOW, 8'h80);
    clean();
    @(posedge mclk);
    openSense <= 1'b1;
    settle();
    strobe(1'b0);
    rd(OFS_STATUS, 8'h04);
    pins(1'b0, 1'b1);
    @(posedge mclk);
    openSense <= 1'b0;
    settle();
    strobe(1'b0);
    clean();
    pins(1'b0, 1'b0);
    wr(OFS_CTRL, 8'h03);
    push(1'b1, 8'h31);
    pins(1'b0, 1'b1);
    chk(32'(araHit), 32'h0);
    push(1'b1, 8'h2C);
    pins(1'b0, 1'b1);
    push(1'b1, 8'h2B);
    pins(1'b0, 1'b0);
    give_verdict();
  end
endmodule
